// ---- rtl/csw_irq.sv ----
`timescale 1ns/1ps
`include "csw_map.svh"
module csw_irq
   import csw_pkg::*;
(
   input wire logic  clock_i,
   input wire logic  reset_n_i,
   csw_irq_if.unit   irq_bus
);
   csw_irq_t stat_ff;
   csw_irq_t mask_ff;
   logic     irq_ff;
   csw_irq_t nxt_stat;
   csw_irq_t clr_bits;

   // ==================================================
   // sticky status: a set in the clear cycle wins
   assign clr_bits = irq_bus.stat_clr_we ? irq_bus.wdata : 3'h0;
   assign nxt_stat = (stat_ff & ~clr_bits) | irq_bus.event_set;

   // status, mask and the level output
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stat_ff <= 3'h0;
         mask_ff <= `CSW_RST_MASK;
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         if (irq_bus.mask_we) begin
            mask_ff <= irq_bus.wdata;
         end
         irq_ff <= |(nxt_stat & (irq_bus.mask_we ? irq_bus.wdata : mask_ff));
      end
   end

   assign irq_bus.stat = stat_ff;
   assign irq_bus.mask = mask_ff;
   assign irq_bus.irq  = irq_ff;
endmodule // csw_irq

// ---- rtl/csw_irq_if.sv ----
`timescale 1ns/1ps
interface csw_irq_if;
   import csw_pkg::*;
   csw_irq_t event_set;   // one-cycle event pulses
   logic     stat_clr_we; // write-one-to-clear strobe
   logic     mask_we;     // mask write strobe
   csw_irq_t wdata;       // write data for both
   csw_irq_t stat;        // sticky status
   csw_irq_t mask;        // enable mask
   logic     irq;         // registered interrupt level

   modport core (output event_set, stat_clr_we, mask_we, wdata,
                 input  stat, mask, irq);
   modport unit (input  event_set, stat_clr_we, mask_we, wdata,
                 output stat, mask, irq);
endinterface

// ---- rtl/csw_map.svh ----
`ifndef CSW_MAP_SVH
`define CSW_MAP_SVH
// ==================================================
// register offsets (byte addresses, one word each)
`define CSW_OFS_CTRL      8'h00
`define CSW_OFS_CHIP      8'h04
`define CSW_OFS_STAT      8'h08
`define CSW_OFS_IRQ_STAT  8'h0C
`define CSW_OFS_IRQ_MASK  8'h10
// ==================================================
// field positions
`define CSW_CTRL_CFGV     3
`define CSW_STAT_ERR      0
`define CSW_STAT_ARMED    1
`define CSW_STAT_SIL      2
`define CSW_STAT_WOKEN    3
`define CSW_IRQ_WAKE      0
`define CSW_IRQ_ERR       1
`define CSW_IRQ_SIL       2
// ==================================================
// mode field codes
`define CSW_MODE_OFF      3'h0
`define CSW_MODE_WK       3'h1
`define CSW_MODE_SWK      3'h5
// chip mode command codes
`define CSW_CMD_NORMAL    2'h0
`define CSW_CMD_STOP      2'h1
`define CSW_CMD_SLEEP     2'h2
// ==================================================
// reset values
`define CSW_RST_MODE      3'h0
`define CSW_RST_MASK      3'h0
`endif

// ---- rtl/csw_mode_ctrl.sv ----
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "csw_map.svh"
module csw_mode_ctrl
   import csw_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        reset_n_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        wake_frame_i,
   input  wire logic        wake_pattern_i,
   input  wire logic        bus_silent_i,
   input  wire logic        cnt_overflow_i,
   input  wire logic        cfg_check_fail_i,
   input  wire logic        bus_rxd_i,
   input  wire logic        mcu_txd_i,
   output logic             rxd_o,
   output logic             bus_txd_o,
   output logic             tx_en_o,
   output logic      [2:0]  eff_mode_o,
   output logic      [1:0]  chip_mode_o,
   output logic             irq_o
);
   // ==================================================
   // state and declarations
   csw_chip_e chip_ff;
   csw_chip_e nxt_chip;
   csw_mode_t mode_ff;
   csw_mode_t nxt_mode;
   logic      cfgv_ff;
   logic      nxt_cfgv;
   logic      err_ff;
   logic      nxt_err;
   logic      sil_ff;
   logic      nxt_sil;
   logic      woken_ff;
   logic      nxt_woken;
   logic      left_ff;
   logic      nxt_left;
   logic [31:0] rdata_ff;
   logic [2:0]  eff_ff;
   logic        rxd_ff;
   logic        txd_ff;
   logic        txen_ff;
   logic [1:0]  rxd_sync_ff;
   logic [1:0]  txd_sync_ff;

   csw_irq_if irq_bus ();

   // ==================================================
   // helpers
   // a code with msb set and a live low pair selects selective wake
   function automatic logic is_swk(input csw_mode_t m);
      is_swk = m[2] & (m[1:0] != 2'h0);
   endfunction

   // effective transceiver mode: msb means wake function live
   function automatic logic [2:0] eff_of(input csw_mode_t m,
                                         input logic e);
      if (m[1:0] == 2'h0) begin
         eff_of = `CSW_MODE_OFF;
      end else begin
         eff_of = {is_swk(m) & ~e, m[1:0]};
      end
   endfunction

   // ==================================================
   // pin synchronisers: bus data and controller transmit data
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rxd_sync_ff <= 2'h3;
         txd_sync_ff <= 2'h3;
      end else begin
         rxd_sync_ff <= {rxd_sync_ff[0], bus_rxd_i};
         txd_sync_ff <= {txd_sync_ff[0], mcu_txd_i};
      end
   end

   // ==================================================
   // register bus decode
   wire sel_ctrl   = (addr_i == `CSW_OFS_CTRL);
   wire sel_chip   = (addr_i == `CSW_OFS_CHIP);
   wire sel_stat   = (addr_i == `CSW_OFS_STAT);
   wire sel_istat  = (addr_i == `CSW_OFS_IRQ_STAT);
   wire sel_imask  = (addr_i == `CSW_OFS_IRQ_MASK);
   wire wr_ctrl    = wr_i & sel_ctrl;
   wire wr_chip    = wr_i & sel_chip;
   wire wr_stat    = wr_i & sel_stat;
   wire in_normal  = (chip_ff == CHIP_NORMAL);
   wire [2:0] wmode = wdata_i[2:0];
   wire       wcfgv = wdata_i[`CSW_CTRL_CFGV];

   // field writes take effect only in Normal
   wire mode_wr_ok = wr_ctrl & in_normal;

   // ==================================================
   // selective wake qualification
   wire swk_sel    = is_swk(mode_ff);
   wire swk_active = swk_sel & ~err_ff;
   wire wk_plain   = (mode_ff == `CSW_MODE_WK) | (swk_sel & err_ff);
   wire armed      = swk_active & ~woken_ff;

   // frames count only with a clean wake function
   wire frame_hit  = wake_frame_i & armed;
   wire low_power  = (chip_ff == CHIP_STOP) | (chip_ff == CHIP_SLEEP);
   wire pattern_hit = wake_pattern_i & wk_plain & ~woken_ff & low_power;
   wire wake_ev    = frame_hit | pattern_hit;

   // config check at enable: wake mode with config not marked valid
   wire enable_fail = mode_wr_ok & is_swk(wmode) & ~wcfgv;
   wire enable_ok   = mode_wr_ok & is_swk(wmode) & wcfgv & ~swk_sel;
   wire err_set     = (swk_sel & (cfg_check_fail_i | cnt_overflow_i))
                    | enable_fail;
   wire err_clr     = (wr_stat & wdata_i[`CSW_STAT_ERR]) | enable_ok;

   // chip command acceptance: low power only from Normal
   wire [1:0] cmd  = wdata_i[1:0];
   wire go_stop    = wr_chip & in_normal & (cmd == `CSW_CMD_STOP);
   wire go_sleep   = wr_chip & in_normal & (cmd == `CSW_CMD_SLEEP);
   wire go_normal  = wr_chip & (cmd == `CSW_CMD_NORMAL)
                   & ((chip_ff == CHIP_STOP) | (chip_ff == CHIP_RESTART));

   // sleep remap of the field: receive/normal fold to wake capable
   wire [2:0] sleep_mode =
      (mode_ff[1:0] == 2'h0) ? mode_ff :            // off codes kept
      swk_sel               ? `CSW_MODE_SWK :
                              `CSW_MODE_WK;

   // ==================================================
   // next-state logic, all mappings on the accepting edge
   always_comb begin
      nxt_chip  = chip_ff;
      nxt_mode  = mode_ff;
      nxt_cfgv  = cfgv_ff;
      nxt_err   = err_ff;
      nxt_sil   = sil_ff;
      nxt_woken = woken_ff;
      nxt_left  = left_ff;
      // host writes of field and config valid
      if (mode_wr_ok) begin
         nxt_mode = wmode;
         nxt_cfgv = wcfgv;
         if (woken_ff & (wmode != mode_ff)) begin
            nxt_left = 1'b1;
         end
         if (left_ff & ((wmode == `CSW_MODE_WK) | is_swk(wmode))) begin
            nxt_woken = 1'b0;
            nxt_left  = 1'b0;
         end
      end
      // error flag: a set beats a clear in the same cycle
      if (err_clr) begin
         nxt_err = 1'b0;
      end
      if (err_set) begin
         nxt_err = 1'b1;
      end
      // silence flag: cleared by a pattern, set while monitoring
      if (wake_pattern_i | (wr_stat & wdata_i[`CSW_STAT_SIL])) begin
         nxt_sil = 1'b0;
      end
      if (bus_silent_i & swk_active) begin
         nxt_sil = 1'b1;
      end
      // chip transitions
      if (go_stop) begin
         nxt_chip = CHIP_STOP;
      end else if (go_sleep) begin
         nxt_chip  = CHIP_SLEEP;
         nxt_mode  = sleep_mode;
         nxt_woken = 1'b0;
         nxt_left  = 1'b0;
      end else if (go_normal) begin
         nxt_chip = CHIP_NORMAL;
      end
      // wake handling; a wake in sleep restarts the chip
      if (wake_ev) begin
         nxt_woken = 1'b1;
         nxt_left  = 1'b0;
         if (chip_ff == CHIP_SLEEP) begin
            nxt_chip = CHIP_RESTART;
            nxt_cfgv = 1'b0;
         end
      end
   end

   // ==================================================
   // control state
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         chip_ff  <= CHIP_NORMAL;
         mode_ff  <= `CSW_RST_MODE;
         cfgv_ff  <= 1'b0;
         err_ff   <= 1'b0;
         sil_ff   <= 1'b0;
         woken_ff <= 1'b0;
         left_ff  <= 1'b0;
      end else begin
         chip_ff  <= nxt_chip;
         mode_ff  <= nxt_mode;
         cfgv_ff  <= nxt_cfgv;
         err_ff   <= nxt_err;
         sil_ff   <= nxt_sil;
         woken_ff <= nxt_woken;
         left_ff  <= nxt_left;
      end
   end

   // ==================================================
   // transceiver outputs, computed from next state so that the
   // new mode appears whole, never a half-mapped mix
   wire [2:0] nxt_eff   = eff_of(nxt_mode, nxt_err);
   wire       nxt_rx_on = nxt_eff[1] & (nxt_chip != CHIP_SLEEP);
   wire       nxt_tx_on = (nxt_eff[1:0] == 2'h3)
                        & (nxt_chip != CHIP_SLEEP);
   // rxd low flags a latched wake; a frame wake keeps it high only in its own hit cycle
   wire       nxt_rxd   = nxt_rx_on ? rxd_sync_ff[1] :
                          ~(nxt_woken & ~frame_hit);

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         eff_ff  <= `CSW_MODE_OFF;
         txen_ff <= 1'b0;
         rxd_ff  <= 1'b1;
         txd_ff  <= 1'b1;
      end else begin
         eff_ff  <= nxt_eff;
         txen_ff <= nxt_tx_on;
         rxd_ff  <= nxt_rxd;
         txd_ff  <= nxt_tx_on ? txd_sync_ff[1] : 1'b1;
      end
   end

   // ==================================================
   // interrupt unit hookup
   assign irq_bus.event_set   = {bus_silent_i & swk_active & ~sil_ff,
                                 err_set & ~err_ff,
                                 wake_ev & (chip_ff != CHIP_SLEEP)};
   assign irq_bus.stat_clr_we = wr_i & sel_istat;
   assign irq_bus.mask_we     = wr_i & sel_imask;
   assign irq_bus.wdata       = wdata_i[2:0];

   csw_irq u_irq (
      .clock_i   (clock_i),
      .reset_n_i (reset_n_i),
      .irq_bus   (irq_bus)
   );

   // ==================================================
   // read mux; unmapped addresses read zero
   wire [31:0] rd_ctrl = {28'h0, cfgv_ff, mode_ff};
   wire [31:0] rd_chip = {30'h0, chip_ff};
   wire [31:0] rd_stat = {25'h0, eff_ff, woken_ff, sil_ff,
                          armed, err_ff};
   wire [31:0] rd_mux  =
      sel_ctrl  ? rd_ctrl :
      sel_chip  ? rd_chip :
      sel_stat  ? rd_stat :
      sel_istat ? {29'h0, irq_bus.stat} :
      sel_imask ? {29'h0, irq_bus.mask} : 32'h0;

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_ff <= 32'h0;
      end else begin
         rdata_ff <= rd_i ? rd_mux : 32'h0;
      end
   end

   // ==================================================
   // outputs straight from flops
   assign rdata_o     = rdata_ff;
   assign rxd_o       = rxd_ff;
   assign bus_txd_o   = txd_ff;
   assign tx_en_o     = txen_ff;
   assign eff_mode_o  = eff_ff;
   assign chip_mode_o = chip_ff;
   assign irq_o       = irq_bus.irq;
endmodule // csw_mode_ctrl

// ---- rtl/csw_pkg.sv ----
package csw_pkg;
   // ==================================================
   // chip power states
   typedef enum logic [1:0] {
      CHIP_NORMAL,
      CHIP_STOP,
      CHIP_SLEEP,
      CHIP_RESTART
   } csw_chip_e;

   typedef logic [2:0] csw_mode_t;
   typedef logic [2:0] csw_irq_t;
endpackage

// ---- verif/can_selective_wake_mode_control_test.sv ----
`timescale 1ns/1ps
module can_selective_wake_mode_control_test;
   import csw_pkg::*;
   logic        clock_i, reset_n_i, wr_i, rd_i, mcu_txd_i, rxd_o, bus_rxd_i;
   logic        bus_txd_o, tx_en_o, irq_o, talk;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [4:0]  ev;
   logic [2:0]  eff_mode_o;
   logic [1:0]  chip_mode_o;
   int          error_cnt = 0;
   int          checked = 0;
   // ==================================================
   // clock, stimulus defaults, models
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   initial {reset_n_i, wr_i, rd_i, addr_i, wdata_i, ev, talk, mcu_txd_i} = 1'b1;
   // controller chatters too, so the transmit path is exercised
   always @(posedge clock_i) mcu_txd_i <= talk ? ~mcu_txd_i : 1'b1;
   csw_bus_node u_node (.clock_i(clock_i), .talk_i(talk), .tx_en_i(tx_en_o),
      .bus_txd_i(bus_txd_o), .bus_rxd_o(bus_rxd_i));
   csw_mode_ctrl DUT (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .wake_frame_i(ev[0]), .wake_pattern_i(ev[1]), .bus_silent_i(ev[2]),
      .cnt_overflow_i(ev[3]), .cfg_check_fail_i(ev[4]), .bus_rxd_i(bus_rxd_i),
      .mcu_txd_i(mcu_txd_i), .rxd_o(rxd_o), .bus_txd_o(bus_txd_o), .tx_en_o(tx_en_o),
      .eff_mode_o(eff_mode_o), .chip_mode_o(chip_mode_o), .irq_o(irq_o));
   // ==================================================
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge clock_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask
   task automatic pulse(input int i);
      @(posedge clock_i);
      ev[i] <= 1'b1;
      @(posedge clock_i);
      ev[i] <= 1'b0;
      #1;
   endtask
   task automatic rst();
      reset_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==================================================
   // scenarios
   task automatic s_decode();
      chk({rxd_o, bus_txd_o, tx_en_o, irq_o, chip_mode_o, eff_mode_o}, 32'h180);
      rd(8'h10, 32'h0);
      for (int c = 0; c < 8; c++) begin
         wr(8'h00, 32'(8 + c));
         chk(eff_mode_o, (c == 4) ? 0 : c);
         chk(tx_en_o, c[1:0] == 2'h3);
         rd(8'h00, 32'(8 + c));
      end
   endtask
   task automatic s_traffic();
      talk <= 1'b1;
      wr(8'h10, 32'h1);
      pulse(0);
      tick();
      chk(irq_o, 1'b1);
      rd(8'h0C, 32'h1);
      wr(8'h0C, 32'h1);
      tick();
      chk(irq_o, 1'b0);
      pulse(0);
      rd(8'h0C, 32'h0);
      wr(8'h00, 32'hE);
      wr(8'h00, 32'hF);
      pulse(0);
      rd(8'h0C, 32'h1);
      wr(8'h0C, 32'h7);
      wr(8'h10, 32'h0);
      pulse(2);
      rd(8'h0C, 32'h4);
      chk(irq_o, 1'b0);
      rd(8'h14, 32'h0);
      wr(8'h0C, 32'h7);
   endtask
   task automatic s_error();
      // rearm first, so that only the error flag can block the frame below
      wr(8'h00, 32'hE);
      wr(8'h00, 32'hF);
      rd(8'h08, 32'h76);
      pulse(4);
      chk(eff_mode_o, 3'h3);
      rd(8'h0C, 32'h2);
      pulse(0);
      rd(8'h0C, 32'h2);
      rd(8'h00, 32'hF);
      wr(8'h04, 32'h1);
      chk(chip_mode_o, 2'h1);
      chk(eff_mode_o, 3'h3);
      wr(8'h00, 32'h9);
      rd(8'h00, 32'hF);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h1);
      chk(eff_mode_o, 3'h7);
      wr(8'h00, 32'hE);
      wr(8'h04, 32'h1);
      chk(eff_mode_o, 3'h6);
      wr(8'h04, 32'h0);
   endtask
   task automatic s_sleep();
      for (int c = 0; c < 8; c++) begin
         rst();
         wr(8'h00, 32'(8 + c));
         wr(8'h04, 32'h2);
         chk(eff_mode_o, (c == 4 || c == 0) ? 0 : (c > 4 ? 5 : 1));
         rd(8'h00, 32'(8 + ((c == 2 || c == 3) ? 1 : (c > 4 ? 5 : c))));
      end
      pulse(0);
      chk(chip_mode_o, 2'h3);
      rd(8'h00, 32'h5);
      rd(8'h0C, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'hA);
      wr(8'h08, 32'h1);
      wr(8'h00, 32'hD);
      wr(8'h04, 32'h2);
      chk(eff_mode_o, 3'h5);
      rst();
      wr(8'h00, 32'hF);
      pulse(0);
      wr(8'h04, 32'h2);
      chk(eff_mode_o, 3'h5);
      pulse(0);
      chk(chip_mode_o, 2'h3);
      rst();
      wr(8'h00, 32'hE);
      pulse(3);
      wr(8'h04, 32'h2);
      chk(eff_mode_o, 3'h1);
      rd(8'h00, 32'hD);
      pulse(1);
      chk(chip_mode_o, 2'h3);
   endtask
   // ==================================================
   // main sequence and hang guard
   initial begin
      rst();
      s_decode();
      s_traffic();
      s_error();
      s_sleep();
      end_sim();
   end
   initial begin
      #200000;
      error_cnt++;
      end_sim();
   end
endmodule // can_selective_wake_mode_control_test

// ---- verif/csw_bus_node.sv ----
`timescale 1ns/1ps
// ==================================================
// far bus node: wired-and bus, recessive high when nobody pulls low
module csw_bus_node (
   input  wire logic clock_i,
   input  wire logic talk_i,
   input  wire logic tx_en_i,
   input  wire logic bus_txd_i,
   output logic      bus_rxd_o
);
   logic bit_ff = 1'b1;
   // chatter every cycle so a stuck receive path cannot pass
   always_ff @(posedge clock_i) begin
      bit_ff <= talk_i ? ~bit_ff : 1'b1;
   end
   assign bus_rxd_o = bit_ff & (tx_en_i ? bus_txd_i : 1'b1);
endmodule // csw_bus_node

// ---- verif/csw_mode_ctrl_props.sv ----
`timescale 1ns/1ps
module csw_mode_ctrl_props
   import csw_pkg::*;
(
   input wire logic        clock_i,
   input wire logic        reset_n_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic        wake_frame_i,
   input wire logic        wake_pattern_i,
   input wire logic        cnt_overflow_i,
   input wire logic        cfg_check_fail_i,
   input wire logic        bus_rxd_i,
   input wire logic        mcu_txd_i,
   input wire logic        rxd_o,
   input wire logic        bus_txd_o,
   input wire logic        tx_en_o,
   input wire logic [2:0]  eff_mode_o,
   input wire logic [1:0]  chip_mode_o
);
   // qualifiers: events that may legally move the mode are kept out
   wire quiet = !(wake_frame_i || wake_pattern_i || cnt_overflow_i || cfg_check_fail_i);
   wire cmd_w = wr_i && addr_i == 8'h04 && chip_mode_o == 2'h0;
   wire fwd   = eff_mode_o[1] && chip_mode_o != 2'h2;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   // ==================================================
   // assertions
   rd_slot_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its slot");
   ro_silent_a: assert property (eff_mode_o[1:0] != 2'h3 |-> !tx_en_o)
      else $error("transmitter on outside normal mode");
   tx_path_a: assert property (tx_en_o && $past(tx_en_o)
      |-> bus_txd_o == $past(mcu_txd_i, 3))
      else $error("transmit data not forwarded");
   rx_path_a: assert property (fwd && $past(fwd) |-> rxd_o == $past(bus_rxd_i, 3))
      else $error("receive data not forwarded");
   sleep_set_a: assert property (chip_mode_o == 2'h2
      |-> eff_mode_o inside {3'h0, 3'h1, 3'h5})
      else $error("illegal mode in sleep");
   sleep_entry_a: assert property (cmd_w && wdata_i[1:0] == 2'h2 |=> chip_mode_o == 2'h2)
      else $error("sleep not entered on accepting edge");
   stop_keep_a: assert property (cmd_w && wdata_i[1:0] == 2'h1 && quiet
      |=> chip_mode_o == 2'h1 && $stable(eff_mode_o))
      else $error("stop entry changed the mode");
   lowpow_lock_a: assert property (wr_i && addr_i == 8'h00
      && chip_mode_o inside {2'h1, 2'h2} && quiet |=> $stable(eff_mode_o))
      else $error("mode write taken in low power");
   wake_restart_a: assert property (chip_mode_o == 2'h2 && eff_mode_o == 3'h5
      && wake_frame_i |=> chip_mode_o == 2'h3)
      else $error("frame in sleep did not restart");
   // main scenarios reached
   cov_restart: cover property (chip_mode_o == 2'h3);
   cov_stop_ro: cover property (chip_mode_o == 2'h1 && eff_mode_o == 3'h6);
   cov_tx: cover property (tx_en_o && $past(tx_en_o));
endmodule // csw_mode_ctrl_props

bind csw_mode_ctrl csw_mode_ctrl_props u_props (.clock_i(clock_i), .reset_n_i(reset_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .wake_frame_i(wake_frame_i), .wake_pattern_i(wake_pattern_i),
   .cnt_overflow_i(cnt_overflow_i), .cfg_check_fail_i(cfg_check_fail_i),
   .bus_rxd_i(bus_rxd_i), .mcu_txd_i(mcu_txd_i), .rxd_o(rxd_o), .bus_txd_o(bus_txd_o),
   .tx_en_o(tx_en_o), .eff_mode_o(eff_mode_o), .chip_mode_o(chip_mode_o));
